// ### verilog/ars_sequencer.v
// Repeat and sweep sequencer for a successive approximation converter, with APB registers.
// Assumes the converter core accepts a start pulse on the divided clock enable and
// returns a done pulse with the comparison register value; trigger pin is asynchronous.
//
// What this block does
// - Conversion clock selectable /4, /2, /1; resolution 8 or 10 bits.
// - Repeat mode converts one chosen channel among inputs 0 to 7.
// - Repeat mode starts when software writes one to start flag.
// - Repeat: first result stored to channel register, no complete request.
// - Repeat: converts back to back, overwriting result each time.
// - Repeat mode runs until software writes zero to start flag.
// - Sweep group selectable as 2, 4, 6 or 8 channels.
// - Single sweep begins on channel 0, result into register 0.
// - Single sweep converts each channel, storing each result per channel.
// - Single sweep sets complete request after last channel.
// - End of single sweep clears start flag and halts converter.
// - Repeat sweep 0 stores every channel, never sets complete request.
// - Repeat sweep 0 sweeps continuously until start flag written zero.
// - External trigger falling edge starts; new edge during conversion restarts.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "ars_consts.vh"
module ars_sequencer
#(
   parameter DW = 10
)
(
   // Clock and reset
   input  wire          clk_i,
   input  wire          rst_i,
   // APB slave
   input  wire          psel_i,
   input  wire          penable_i,
   input  wire          pwrite_i,
   input  wire [11:0]   paddr_i,
   input  wire [31:0]   pwdata_i,
   output wire          pready_o,
   output reg  [31:0]   prdata_o,
   output wire          pslverr_o,
   // Trigger pin, active low edge
   input  wire          ext_conv_trigger_n_i,
   // Converter core
   output reg           conv_start_o,
   output reg           conv_abort_o,
   output reg  [2:0]    analog_channel_in_o,
   output reg           conv_res10_o,
   output wire          conv_clk_en_o,
   input  wire          conv_done_i,
   input  wire [DW-1:0] conv_result_i,
   // Interrupt
   output wire          irq_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_CONV = 2'h2;

   reg  [11:0]   ctrl;
   reg           stat_done;
   reg           mask_done;
   reg  [1:0]    state;
   reg  [1:0]    div_cnt;
   reg  [2:0]    chan;
   reg           trg_s1;
   reg           trg_s2;
   reg           trg_d;
   reg           mem_we;
   reg  [2:0]    mem_waddr;
   reg  [DW-1:0] mem_wdata;
   reg           next_conv_start;
   wire [DW-1:0] mem_rdata;
   wire          start    = ctrl[`ARS_CTRL_START];
   wire [1:0]    mode     = ctrl[`ARS_CTRL_MODE_HI:`ARS_CTRL_MODE_LO];
   wire [1:0]    grp      = ctrl[`ARS_CTRL_GRP_HI:`ARS_CTRL_GRP_LO];
   wire [1:0]    div_sel  = ctrl[`ARS_CTRL_DIV_HI:`ARS_CTRL_DIV_LO];
   wire          ext_sel  = ctrl[`ARS_CTRL_EXTTRG];
   wire [2:0]    last_ch  = {grp, 1'b1};
   wire          trg_fall = trg_d & ~trg_s2;
   wire          apb_wr   = psel_i & penable_i & pwrite_i;
   wire          apb_rd   = psel_i & penable_i & ~pwrite_i;
   wire          rd_stat  = apb_rd & (paddr_i == `ARS_STAT_OFS);
   wire          is_res   = ((paddr_i & 12'hfe3) == `ARS_RES_BASE_OFS);
   wire          mapped   = (paddr_i == `ARS_CTRL_OFS) | (paddr_i == `ARS_STAT_OFS) |
                            (paddr_i == `ARS_MASK_OFS) | is_res;
   wire          sweep_end;
   wire          sw_stop;

   // Result reads need one extra cycle for the registered memory port
   reg rd_wait;
   assign pready_o  = ~(psel_i & penable_i & ~pwrite_i & is_res & ~rd_wait);
   assign pslverr_o = psel_i & penable_i & ~mapped;
   assign irq_o     = stat_done & mask_done;
   assign sweep_end = conv_done_i & (state == ST_CONV) & (mode == `ARS_MODE_SWEEP) &
                      (chan == last_ch);
   assign sw_stop   = apb_wr & (paddr_i == `ARS_CTRL_OFS) & ~pwdata_i[`ARS_CTRL_START];

   // Clock enable divider, free running from reset; the selection only picks which counts enable
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_cnt <= 2'h0;
      end
      else
      begin
         div_cnt <= div_cnt + 2'h1;
      end
   end
   assign conv_clk_en_o = (div_sel == `ARS_DIV_1) ? 1'b1 :
                          (div_sel == `ARS_DIV_2) ? div_cnt[0] :
                          (div_cnt == 2'h3);

   // Trigger pin synchroniser then edge history
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trg_s1 <= 1'b1;
         trg_s2 <= 1'b1;
         trg_d  <= 1'b1;
      end
      else
      begin
         trg_s1 <= ext_conv_trigger_n_i;
         trg_s2 <= trg_s1;
         trg_d  <= trg_s2;
      end
   end

   // Control, mask and sticky status registers
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl      <= `ARS_CTRL_RST;
         mask_done <= `ARS_MASK_RST;
         stat_done <= 1'b0;
      end
      else
      begin
         if (apb_wr & (paddr_i == `ARS_CTRL_OFS))
         begin
            ctrl <= pwdata_i[11:0];
         end
         else if (sweep_end)
         begin
            ctrl[`ARS_CTRL_START] <= 1'b0;
         end
         if (apb_wr & (paddr_i == `ARS_MASK_OFS))
         begin
            mask_done <= pwdata_i[`ARS_STAT_DONE];
         end
         // Set wins over read-to-clear so no sweep end is lost
         if (sweep_end)
         begin
            stat_done <= 1'b1;
         end
         else if (rd_stat)
         begin
            stat_done <= 1'b0;
         end
      end
   end

   // Sequencer: waits for trigger, issues conversions, steps channels
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state               <= ST_IDLE;
         chan                <= 3'h0;
         conv_start_o        <= 1'b0;
         conv_abort_o        <= 1'b0;
         analog_channel_in_o <= 3'h0;
         conv_res10_o        <= 1'b0;
         mem_we              <= 1'b0;
         mem_waddr           <= 3'h0;
         mem_wdata           <= {DW{1'b0}};
      end
      else
      begin
         conv_start_o <= next_conv_start;
         conv_abort_o <= 1'b0;
         mem_we       <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (start & ~sw_stop)
               begin
                  chan         <= (mode == `ARS_MODE_REPEAT) ?
                                  ctrl[`ARS_CTRL_CH_HI:`ARS_CTRL_CH_LO] : 3'h0;
                  conv_res10_o <= ctrl[`ARS_CTRL_RES10];
                  state        <= ext_sel ? ST_WAIT : ST_CONV;
               end
            end
            ST_WAIT:
            begin
               if (~start)
               begin
                  state <= ST_IDLE;
               end
               else if (trg_fall)
               begin
                  state <= ST_CONV;
               end
            end
            ST_CONV:
            begin
               analog_channel_in_o <= chan;
               if (~start)
               begin
                  conv_abort_o <= 1'b1;
                  state        <= ST_IDLE;
               end
               else if (ext_sel & trg_fall)
               begin
                  conv_abort_o <= 1'b1;
                  chan         <= (mode == `ARS_MODE_REPEAT) ? chan : 3'h0;
               end
               else if (conv_done_i)
               begin
                  mem_we    <= 1'b1;
                  mem_waddr <= chan;
                  mem_wdata <= conv_result_i;
                  if (mode != `ARS_MODE_REPEAT)
                  begin
                     chan <= (chan == last_ch) ? 3'h0 : chan + 3'h1;
                  end
                  if (sweep_end)
                  begin
                     state <= ST_IDLE;
                  end
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Start pulse the cycle after the next conversion enable following entry or completion
   reg conv_busy;
   always @*
   begin
      next_conv_start = 1'b0;
      if ((state == ST_CONV) & start & ~conv_busy & ~conv_start_o & conv_clk_en_o)
      begin
         next_conv_start = 1'b1;
      end
   end

   // Busy tracks a launched conversion until done or abort
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         conv_busy <= 1'b0;
         rd_wait   <= 1'b0;
      end
      else
      begin
         if (conv_start_o)
         begin
            conv_busy <= 1'b1;
         end
         else if (conv_done_i | conv_abort_o | (state != ST_CONV))
         begin
            conv_busy <= 1'b0;
         end
         rd_wait <= apb_rd & is_res & ~rd_wait;
      end
   end

   ars_result_mem
   #(
      .DW (DW),
      .AW (3)
   )
   u_mem
   (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .waddr_i (mem_waddr),
      .wdata_i (mem_wdata),
      .raddr_i (paddr_i[4:2]),
      .rdata_o (mem_rdata)
   );

   // Read data mux; 8-bit results sit in the low bits
   always @*
   begin
      prdata_o = 32'h0000_0000;
      if (is_res)
      begin
         prdata_o[DW-1:0] = mem_rdata;
      end
      else if (paddr_i == `ARS_CTRL_OFS)
      begin
         prdata_o[11:0] = ctrl;
      end
      else if (paddr_i == `ARS_STAT_OFS)
      begin
         prdata_o[0] = stat_done;
         prdata_o[1] = (state != ST_IDLE);
      end
      else if (paddr_i == `ARS_MASK_OFS)
      begin
         prdata_o[0] = mask_done;
      end
   end
endmodule // ars_sequencer

// ### verilog/ars_consts.vh
// Constants for the converter sequencer: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ARS_CONSTS_VH
`define ARS_CONSTS_VH
// Register byte offsets
`define ARS_CTRL_OFS      12'h000
`define ARS_STAT_OFS      12'h004
`define ARS_MASK_OFS      12'h008
`define ARS_RES_BASE_OFS  12'h020
// Control field positions
`define ARS_CTRL_START    0
`define ARS_CTRL_MODE_LO  1
`define ARS_CTRL_MODE_HI  2
`define ARS_CTRL_CH_LO    3
`define ARS_CTRL_CH_HI    5
`define ARS_CTRL_GRP_LO   6
`define ARS_CTRL_GRP_HI   7
`define ARS_CTRL_DIV_LO   8
`define ARS_CTRL_DIV_HI   9
`define ARS_CTRL_RES10    10
`define ARS_CTRL_EXTTRG   11
// Modes
`define ARS_MODE_REPEAT   2'h0
`define ARS_MODE_SWEEP    2'h1
`define ARS_MODE_RSWEEP0  2'h2
// Clock divisions
`define ARS_DIV_4         2'h0
`define ARS_DIV_2         2'h1
`define ARS_DIV_1         2'h2
// Status bits
`define ARS_STAT_DONE     0
// Reset values
`define ARS_CTRL_RST      12'h000
`define ARS_MASK_RST      1'h0
`endif

// ### verilog/ars_result_mem.v
// Result store: one word per analog channel, registered read port.
// Assumes a single clock and a synchronous write strobe from the sequencer.
`timescale 1ns/1ps
module ars_result_mem
#(
   parameter DW = 10,
   parameter AW = 3
)
(
   // Clock
   input  wire          clk_i,
   // Write side
   input  wire          we_i,
   input  wire [AW-1:0] waddr_i,
   input  wire [DW-1:0] wdata_i,
   // Read side
   input  wire [AW-1:0] raddr_i,
   output reg  [DW-1:0] rdata_o
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   integer      i;

   // Write and registered read; contents cleared only by writes
   always @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end

   // Defined start contents for simulation and FPGA init
   initial
   begin
      for (i = 0; i < (1<<AW); i = i + 1)
      begin
         mem[i] = {DW{1'b0}};
      end
   end
endmodule // ars_result_mem

// ### test/ars_sequencer_monitor.sv
// Port-level checker for the converter sequencer; shadows control writes off the APB.
// Assumes it is bound onto ars_sequencer and that settings change only while stopped.
`timescale 1ns/1ps
`include "ars_consts.vh"
module ars_sequencer_monitor
(
   // Clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // APB
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire        pready_o,
   input wire        pslverr_o,
   // Converter side and interrupt
   input wire        conv_start_o,
   input wire        conv_abort_o,
   input wire [2:0]  analog_channel_in_o,
   input wire        conv_res10_o,
   input wire        conv_clk_en_o,
   input wire        conv_done_i,
   input wire        irq_o
);
   reg  [11:0] ctl;
   wire        acc    = psel_i && penable_i && pready_o;
   wire        wr_ctl = acc && pwrite_i && paddr_i == `ARS_CTRL_OFS;
   wire        unmap  = (paddr_i >= 12'h00c && paddr_i < 12'h020) || paddr_i >= 12'h040;
   // Plain shadow is enough, since software only retunes a stopped converter
   always @(posedge clk_i)
      if (rst_i)
         ctl <= 12'h000;
      else if (wr_ctl)
         ctl <= pwdata_i[11:0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence res_wait;
      !pready_o ##1 pready_o;
   endsequence
   start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
      else $error("start pulse longer than one cycle");
   abort_pulse_a: assert property (conv_abort_o |=> !conv_abort_o)
      else $error("abort pulse longer than one cycle");
   div_four_a: assert property (conv_clk_en_o && ctl[9:8] == `ARS_DIV_4 && !wr_ctl
      |=> (!conv_clk_en_o || ctl[9:8] != `ARS_DIV_4) [*3]
      ##1 (conv_clk_en_o || ctl[9:8] != `ARS_DIV_4))
      else $error("divide by four enable spacing wrong");
   div_one_a: assert property (ctl[9:8] == `ARS_DIV_1 && $past(ctl[9:8]) == `ARS_DIV_1
      |-> conv_clk_en_o) else $error("undivided enable missing");
   res_select_a: assert property (conv_start_o |-> conv_res10_o == ctl[10])
      else $error("resolution differs from setting");
   repeat_chan_a: assert property (conv_start_o && ctl[2:1] == `ARS_MODE_REPEAT
      |-> analog_channel_in_o == ctl[5:3]) else $error("repeat channel wrong");
   sweep_range_a: assert property (conv_start_o && ctl[2:1] != `ARS_MODE_REPEAT
      |-> analog_channel_in_o <= {ctl[7:6], 1'b1}) else $error("sweep channel outside group");
   unmapped_err_a: assert property (psel_i && penable_i && unmap |-> pslverr_o)
      else $error("no error on unmapped access");
   result_wait_a: assert property (psel_i && penable_i && !$past(penable_i) && !pwrite_i
      && paddr_i[11:5] == 7'h01 && paddr_i[1:0] == 2'h0 |-> res_wait)
      else $error("result read wait wrong");
   irq_clear_a: assert property (acc && !pwrite_i && paddr_i == `ARS_STAT_OFS
      && !conv_done_i && !$past(conv_done_i) |=> !irq_o)
      else $error("status read left interrupt up");
endmodule // ars_sequencer_monitor

bind ars_sequencer ars_sequencer_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_start_o(conv_start_o),
   .conv_abort_o(conv_abort_o), .analog_channel_in_o(analog_channel_in_o),
   .conv_res10_o(conv_res10_o), .conv_clk_en_o(conv_clk_en_o), .conv_done_i(conv_done_i),
   .irq_o(irq_o));

// ### test/ars_core_model.sv
// Behavioural converter core: random length conversions counted on the clock enable.
// Assumes one-cycle start and abort pulses; keeps counters the bench inspects.
`timescale 1ns/1ps
module ars_core_model
(
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Control from the sequencer
   input  wire       en_i,
   input  wire       start_i,
   input  wire       abort_i,
   input  wire       res10_i,
   input  wire [2:0] ch_i,
   // Answer
   output reg        done_o,
   output reg  [9:0] res_o
);
   reg  [9:0] last_res [0:7];
   reg  [2:0] cur;
   reg  [2:0] prev = 3'h0;    // Known start so the order counters never go unknown
   int        busy;
   int        left;
   int        n_done;
   int        wraps;
   int        skips;
   int        aborts;
   // Result bus keeps moving outside done, so a late sample never looks valid
   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      res_o <= rst_i ? 10'h000 : ~res_o;
      if (rst_i || abort_i)
      begin
         aborts = aborts + (busy & !rst_i);
         busy = 0;
      end
      else if (start_i)
      begin
         busy = 1;
         left = $urandom_range(11, 20);
         cur = ch_i;
         wraps = wraps + (ch_i == 3'h0 && prev != 3'h0);
         skips = skips + (ch_i != prev && ch_i != prev + 3'h1 && ch_i != 3'h0);
         prev = ch_i;
      end
      else if (busy && en_i && --left == 0)
      begin
         busy = 0;
         last_res[cur] = 10'($urandom) & (res10_i ? 10'h3ff : 10'h0ff);
         res_o <= last_res[cur];
         done_o <= 1'b1;
         n_done++;
      end
   end
endmodule // ars_core_model

// ### test/ars_sequencer_tb.sv
// Self-checking bench for the sequencer: APB master, core model, read scoreboard.
// Assumes the bound checker and the core model beside the design.
`timescale 1ns/1ps
`include "ars_consts.vh"
module ars_sequencer_tb;
   reg          clk_i = 1'b0;
   reg          rst_i = 1'b1;
   reg          psel_i = 1'b0;
   reg          penable_i = 1'b0;
   reg          pwrite_i = 1'b0;
   reg  [11:0]  paddr_i = 12'h000;
   reg  [31:0]  pwdata_i = 32'h0;
   reg          trg_n = 1'b1;
   wire         pready_o, pslverr_o, irq_o, st, ab, r10, en, done;
   wire [31:0]  prdata_o;
   wire [2:0]   ch;
   wire [9:0]   res;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          g;
   int          n0;
   int          ab0;
   int          sk0;
   logic [31:0] exp_q [$];
   ars_sequencer u_ars_sequencer (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
      .ext_conv_trigger_n_i(trg_n), .conv_start_o(st), .conv_abort_o(ab),
      .analog_channel_in_o(ch), .conv_res10_o(r10), .conv_clk_en_o(en),
      .conv_done_i(done), .conv_result_i(res), .irq_o(irq_o));
   ars_core_model u_ars_core_model (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .start_i(st),
      .abort_i(ab), .res10_i(r10), .ch_i(ch), .done_o(done), .res_o(res));
   always #12.5 clk_i = ~clk_i;
   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard, well above the few thousand cycles the sequence needs
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         report_and_stop;
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e)
      begin
         $display("MISMATCH %s exp %h got %h", n, e, s);
         err_total++;
      end
   endtask
   // Each completed read is scored against the oldest noted expectation
   always @(posedge clk_i)
      if (psel_i && penable_i && pready_o && !pwrite_i)
         chk("prdata", exp_q.pop_front(), prdata_o);
   // Request held until pready is sampled high; the hang guard bounds the wait
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1)
         @(posedge clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      // One idle cycle so a following call never reassigns the strobes in this step
      @(posedge clk_i);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task wait_irq;
      while (irq_o !== 1'b1)
         @(posedge clk_i);
   endtask
   // Single sweep on group k; division and resolution vary with k
   task sweep(input int k);
      int c;
      int i;
      c = 3 + k * 64 + (k % 3) * 256 + (k % 2) * 1024;
      n0 = u_ars_core_model.n_done;
      apb(1'b1, `ARS_CTRL_OFS, c);
      wait_irq;
      chk("conversions", 2 * k + 2, u_ars_core_model.n_done - n0);
      rd(`ARS_CTRL_OFS, c - 1);
      rd(`ARS_STAT_OFS, 32'h1);
      rd(`ARS_STAT_OFS, 32'h0);
      for (i = 0; i < 2 * k + 2; i++)
         rd(`ARS_RES_BASE_OFS + 4 * i, u_ars_core_model.last_res[i]);
   endtask
   initial
   begin
      g = $urandom(10890);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(`ARS_CTRL_OFS, 32'h0);
      rd(`ARS_MASK_OFS, 32'h0);
      rd(12'h010, 32'h0);
      apb(1'b1, `ARS_MASK_OFS, 32'h1);
      for (g = 0; g < 4; g++)
         sweep(g);
      chk("sweep order", 0, u_ars_core_model.skips);
      // Repeat on a random channel, then stop from software
      g = $urandom_range(0, 7);
      n0 = u_ars_core_model.n_done;
      apb(1'b1, `ARS_CTRL_OFS, 1 + g * 8 + 512 + 1024);
      repeat (250) @(posedge clk_i);
      // Stop right after a launch, so no result can land inside the abort window
      while (st !== 1'b1)
         @(posedge clk_i);
      apb(1'b1, `ARS_CTRL_OFS, g * 8 + 512 + 1024);
      chk("repeat runs", 1, u_ars_core_model.n_done - n0 > 4);
      rd(`ARS_STAT_OFS, 32'h0);
      rd(`ARS_RES_BASE_OFS + 4 * g, u_ars_core_model.last_res[g]);
      n0 = u_ars_core_model.n_done;
      repeat (100) @(posedge clk_i);
      chk("stopped", n0, u_ars_core_model.n_done);
      // The jump onto the repeat channel is not a sweep step
      sk0 = u_ars_core_model.skips;
      // Repeat sweep 0 on four channels must wrap and never flag completion
      n0 = u_ars_core_model.wraps;
      apb(1'b1, `ARS_CTRL_OFS, 1 + 4 + 64 + 512);
      repeat (300) @(posedge clk_i);
      apb(1'b1, `ARS_CTRL_OFS, 4 + 64 + 512);
      chk("wraps", 1, u_ars_core_model.wraps - n0 > 1);
      rd(`ARS_STAT_OFS, 32'h0);
      // External trigger: idle until an edge, a second edge mid-conversion restarts
      n0 = u_ars_core_model.n_done;
      ab0 = u_ars_core_model.aborts;
      apb(1'b1, `ARS_CTRL_OFS, 3 + 512 + 2048);
      repeat (40) @(posedge clk_i);
      chk("no trigger", n0, u_ars_core_model.n_done);
      trg_n <= 1'b0;
      while (st !== 1'b1)
         @(posedge clk_i);
      trg_n <= 1'b1;
      repeat (2) @(posedge clk_i);
      trg_n <= 1'b0;
      wait_irq;
      chk("aborted", 1, u_ars_core_model.aborts - ab0);
      chk("after restart", n0 + 2, u_ars_core_model.n_done);
      rd(`ARS_STAT_OFS, 32'h1);
      chk("channel order", sk0, u_ars_core_model.skips);
      report_and_stop;
   end
endmodule // ars_sequencer_tb
